// ===== verif/mrc_ctl_model.sv
// Purpose: Behavioural model of the external controller that drives run, select and analog pins.
// Assumes: Commands come from the bench; HOLD_CYC is the minimum hold and reversal gap in cycles.
// Notes:   A request that would break the hold or gap is delayed; one withdrawn before the gap ends is dropped.
`timescale 1ns/1ps
`default_nettype none
module mrc_ctl_model #(
  parameter int unsigned HOLD_CYC = 500000
) (
  input  wire logic        ref_clk,          // Clock
  input  wire logic        rst_b,            // Synchronous reset
  input  wire logic        cmdFwd,           // Wanted forward level
  input  wire logic        cmdBwd,           // Wanted backward level
  input  wire logic [3:0]  cmdSel,           // Wanted data set
  input  wire logic [13:0] cmdMv,            // Wanted setting voltage
  output logic             forwardRunInput,  // Forward run pin
  output logic             backwardRunInput, // Backward run pin
  output logic [3:0]       dataSelect,       // Data select pins
  output logic [13:0]      analogMv          // Analog setting
);
  logic [31:0] cnt;
  logic        nf;
  logic        nb;

  // A reversal first drops the active input; the opposite one rises after the gap.
  always_comb begin
    nf = cmdFwd;
    nb = cmdBwd;
    if (forwardRunInput && !cmdFwd && !backwardRunInput) nb = 1'b0;
    if (backwardRunInput && !cmdBwd && !forwardRunInput) nf = 1'b0;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      forwardRunInput  <= 1'b0;
      backwardRunInput <= 1'b0;
      dataSelect       <= 4'h0;
      analogMv         <= 14'h0000;
      cnt              <= 32'h00000000;
    end else begin
      dataSelect <= cmdSel;
      analogMv   <= cmdMv;
      if ((nf != forwardRunInput || nb != backwardRunInput) && cnt >= HOLD_CYC) begin
        forwardRunInput  <= nf;
        backwardRunInput <= nb;
        cnt              <= 32'h00000000;
      end else if (cnt < HOLD_CYC) begin
        cnt <= cnt + 32'h00000001;
      end
    end
  end
endmodule // mrc_ctl_model
`default_nettype wire

// ===== verif/tb.sv
// Purpose: Self-checking bench of the run, speed and torque command block.
// Assumes: The register bus answers by lowering waitrequest; controller hold is HOLD cycles.
// Notes:   Expected values are computed here from the documented scaling and clamping.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin badCount++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb;
  import mrc_pkg::*;
  localparam int unsigned HOLD = 8;
  localparam int MILLI = 32'sh000003E8;
  logic ref_clk, rst_b, stopModeIn, cmdFwd, cmdBwd, fwdIn, bwdIn, avWaitrequest;
  logic motorRun, shaftCw, decelStop, instantStop, torqueLimitOn, torqueAtLimitFlag;
  logic [3:0] cmdSel, dSel, tlEn, obs;
  logic [13:0] cmdMv, aMv;
  logic [8:0] motorTorque, torqueLimit, et;
  logic [11:0] speedCmd, es;
  logic [31:0] avReaddata;
  mrc_avreq_s avReq;
  int badCount, numChecks;
  logic [7:0] rstAdr [10];
  logic [31:0] rstVal [10];
  logic [31:0] tMv [5], tG [5], tO [5], tH [5];

  assign obs = {torqueAtLimitFlag, instantStop, decelStop, motorRun};
  always #10 ref_clk = ~ref_clk;

  mrc_core #(.TL_TERMS(4), .DATA_SETS(16)) mrc_core_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .avReq(avReq), .avWaitrequest(avWaitrequest),
    .avReaddata(avReaddata), .forwardRunInput(fwdIn), .backwardRunInput(bwdIn),
    .stopModeIn(stopModeIn), .torqueLimitEnableInput(tlEn), .dataSelect(dSel),
    .analogMv(aMv), .motorTorque(motorTorque), .motorRun(motorRun), .shaftCw(shaftCw),
    .decelStop(decelStop), .instantStop(instantStop), .speedCmd(speedCmd),
    .torqueLimit(torqueLimit), .torqueLimitOn(torqueLimitOn),
    .torqueAtLimitFlag(torqueAtLimitFlag));

  mrc_ctl_model #(.HOLD_CYC(HOLD)) mrc_ctl_model_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmdFwd(cmdFwd), .cmdBwd(cmdBwd), .cmdSel(cmdSel),
    .cmdMv(cmdMv), .forwardRunInput(fwdIn), .backwardRunInput(bwdIn), .dataSelect(dSel),
    .analogMv(aMv));

  task automatic closeOut();
    $display("checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Request is held until the edge where waitrequest is low; data is taken at that edge.
  task automatic busOp(input logic rw, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
    int n;
    n = 0;
    q = 32'h00000000;
    @(posedge ref_clk);
    avReq <= '{read: !rw, write: rw, address: a, writedata: d, byteenable: 4'hF};
    // Waitrequest and read data are read at the rising edge, before the design updates.
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWaitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      badCount++;
      $display("CHECK FAILED bus wait expected done seen timeout");
      closeOut();
    end else begin
      q = avReaddata;
      avReq <= '0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    busOp(1'b1, a, d, q);
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    busOp(1'b0, a, 32'h00000000, q);
    `CHK(nm, e, q)
  endtask

  task automatic waitObs(input logic [3:0] m, input logic [3:0] v, input string nm);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (((obs & m) !== v) && n < 40);
    `CHK(nm, v, obs & m)
    if (n >= 40) begin
      closeOut();
    end
  endtask

  task automatic drv(input logic f, input logic b);
    @(posedge ref_clk);
    cmdFwd <= f;
    cmdBwd <= b;
  endtask

  task automatic setAna(input logic [13:0] mv, input logic [3:0] s);
    @(posedge ref_clk);
    cmdMv  <= mv;
    cmdSel <= s;
  endtask

  // Model stage plus the one-cycle output latency, with margin.
  task automatic settle();
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask

  function automatic int clampv(int v, int lo, int hi);
    if (v > hi) v = hi;
    if (v < lo) v = lo;
    return v;
  endfunction

  initial begin
    ref_clk = 1'b0; rst_b = 1'b0; avReq = '0; stopModeIn = 1'b0; cmdFwd = 1'b0;
    cmdBwd = 1'b0; cmdSel = 4'h0; cmdMv = 14'h0000; tlEn = 4'h0; motorTorque = 9'h000;
    badCount = 0; numChecks = 0;
    rstAdr = '{OFS_CTRL, OFS_SPD_GAIN, OFS_SPD_OFS, OFS_SPD_HI, OFS_SPD_LO, OFS_TRQ_GAIN,
               OFS_TRQ_OFS, OFS_TRQ_MAX, OFS_DATA, 8'h30};
    rstVal = '{32'h1, 32'h352, 32'h0, 32'hFA0, 32'h32, 32'h41, 32'h0, 32'h12C,
               32'h012C0032, 32'h0};
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 10; i++) rdChk(rstAdr[i], rstVal[i], "reset value");
    $display("test reset values done");

    drv(1'b1, 1'b0);
    waitObs(4'h1, 4'h1, "run forward");
    `CHK("shaftCw forward", 1'b1, shaftCw)
    rdChk(OFS_STATUS, 32'h32, "status forward");
    drv(1'b0, 1'b0);
    waitObs(4'h3, 4'h2, "release decel");
    @(negedge ref_clk);
    `CHK("decel pulse end", 1'b0, decelStop)
    drv(1'b0, 1'b1);
    waitObs(4'h1, 4'h1, "run reverse");
    `CHK("shaftCw reverse", 1'b0, shaftCw)
    drv(1'b1, 1'b1);
    waitObs(4'h3, 4'h2, "both on stop");
    drv(1'b0, 1'b1);
    repeat (HOLD + 4) @(negedge ref_clk);
    `CHK("no restart from hold", 1'b0, motorRun)
    drv(1'b0, 1'b0);
    repeat (HOLD + 4) @(negedge ref_clk);
    wr(OFS_CTRL, 32'h0);
    @(posedge ref_clk);
    stopModeIn <= 1'b1;
    drv(1'b1, 1'b0);
    waitObs(4'h1, 4'h1, "run with dir zero");
    `CHK("shaftCw dir zero", 1'b0, shaftCw)
    drv(1'b0, 1'b0);
    waitObs(4'h5, 4'h4, "instant stop");
    @(posedge ref_clk);
    stopModeIn <= 1'b0;
    $display("test run decoding done");

    tMv = '{32'h3E8, 32'h7D0, 32'h1388, 32'h2328, 32'h1388};
    tG  = '{32'h352, 32'h352, 32'h352, 32'h1A9, 32'h352};
    tO  = '{32'h0, 32'hFFFFF830, 32'h7D0, 32'h0, 32'h0};
    tH  = '{32'hFA0, 32'hFA0, 32'hFA0, 32'hFA0, 32'h7D0};
    wr(OFS_CTRL, 32'h5);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_SPD_GAIN, tG[i]);
      wr(OFS_SPD_OFS, tO[i]);
      wr(OFS_SPD_HI, tH[i]);
      setAna(tMv[i][13:0], 4'h0);
      settle();
      es = 12'(clampv(int'(tG[i]) * int'(tMv[i]) / MILLI + $signed(tO[i]), 32'sh32,
                      int'(tH[i])));
      `CHK("speedCmd analog", es, speedCmd)
      rdChk(OFS_CMD, {7'h00, 9'h12C, 4'h0, es}, "cmd word");
    end
    $display("test analog speed done");

    tMv = '{32'h7D0, 32'h3E8, 32'h2710, 32'hFA0, 32'h0};
    tG  = '{32'h41, 32'h41, 32'h12C, 32'h12C, 32'h0};
    tO  = '{32'h0, 32'hFFFFFF6A, 32'h96, 32'h0, 32'h0};
    tH  = '{32'h12C, 32'h12C, 32'h64, 32'h12C, 32'h0};
    wr(OFS_CTRL, 32'h7);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_TRQ_GAIN, tG[i]);
      wr(OFS_TRQ_OFS, tO[i]);
      wr(OFS_TRQ_MAX, tH[i]);
      setAna(tMv[i][13:0], 4'h0);
      settle();
      et = 9'(clampv(int'(tG[i]) * int'(tMv[i]) / MILLI + $signed(tO[i]), 0, int'(tH[i])));
      `CHK("torqueLimit analog", et, torqueLimit)
    end
    `CHK("speed from data set", 12'h032, speedCmd)
    $display("test analog torque done");

    wr(OFS_CTRL, 32'h1);
    wr(OFS_DATA + 8'h0C, 32'h007803E8);
    setAna(14'h0000, 4'h3);
    settle();
    `CHK("data set speed", 12'h3E8, speedCmd)
    `CHK("data set torque", 9'h078, torqueLimit)
    `CHK("unassigned enable", 1'b1, torqueLimitOn)
    @(posedge ref_clk);
    motorTorque <= 9'h078;
    settle();
    `CHK("at limit", 1'b1, torqueAtLimitFlag)
    @(posedge ref_clk);
    motorTorque <= 9'h077;
    settle();
    `CHK("below limit", 1'b0, torqueAtLimitFlag)
    wr(OFS_CTRL, 32'h51);
    @(posedge ref_clk);
    tlEn <= 4'h5;
    motorTorque <= 9'h0C8;
    settle();
    `CHK("all assigned on", 1'b1, torqueLimitOn)
    `CHK("flag while limiting", 1'b1, torqueAtLimitFlag)
    @(posedge ref_clk);
    tlEn <= 4'h1;
    settle();
    `CHK("one assigned off", 1'b0, torqueLimitOn)
    `CHK("no flag when off", 1'b0, torqueAtLimitFlag)
    $display("test data set and enable done");
    closeOut();
  end
endmodule // tb
`default_nettype wire

// ===== verilog/mrc_core.sv
// Purpose: Run decoding, speed command and torque limit logic of a motor driver.
// Assumes: Pins are synchronous to ref_clk; analogMv is the setting voltage in millivolts.
// Notes:   Registers sit on an Avalon-MM slave that inserts one wait cycle.
// Function
// R1: Forward input alone runs motor forward.
// R2: Backward input alone runs motor reverse.
// R3: Both inputs on while running: decelerating stop.
// R4: Run input released: decelerate, or instant stop.
// R5: Controller holds each run input 10 ms.
// R6: Controller leaves 10 ms before reversing.
// R7: Direction setting maps forward to shaft direction.
// R8: Analog speed is gain times voltage.
// R9: Speed offset added to analog speed.
// R10: Speed command capped at upper limit.
// R11: Speed command floored at lower limit.
// R12: Source select; value three gives analog torque.
// R13: Torque limit value between 0 and 300%.
// R14: Enable on limits torque to set value.
// R15: Enable off disables limiting, peak torque.
// R16: Unassigned enable is on; several need all.
// R17: Flag torque reaching the limit value.
// R18: Flag unstable when limit below 20%.
// R19: Analog torque is gain times voltage.
// R20: Torque offset added to analog limit.
// R21: Analog torque limit clamped to maximum.
// R22: Data select inputs pick stored data set.
// R23: Gain and offset first, then clamp.
`timescale 1ns/1ps
`default_nettype none
module mrc_core #(
  parameter int unsigned TL_TERMS  = 4,
  parameter int unsigned DATA_SETS = 16,
  parameter int unsigned SEL_W     = $clog2(DATA_SETS)
) (
  input  wire logic               ref_clk,       // 50 MHz clock
  input  wire logic               rst_b,         // Synchronous reset
  input  wire mrc_pkg::mrc_avreq_s avReq,        // Avalon-MM request
  output logic                    avWaitrequest, // Avalon-MM wait
  output logic [31:0]             avReaddata,    // Avalon-MM read data
  input  wire logic               forwardRunInput,  // Forward run
  input  wire logic               backwardRunInput, // Backward run
  input  wire logic               stopModeIn,    // High selects instant stop
  input  wire logic [TL_TERMS-1:0] torqueLimitEnableInput, // Enable terminals
  input  wire logic [SEL_W-1:0]   dataSelect,    // Data set, bit0 and bit1 upward
  input  wire logic [13:0]        analogMv,      // Setting voltage in mV
  input  wire logic [8:0]         motorTorque,   // Present torque in percent
  output logic                    motorRun,      // Motor rotating
  output logic                    shaftCw,       // Shaft turns clockwise
  output logic                    decelStop,     // Decelerating stop pulse
  output logic                    instantStop,   // Instant stop pulse
  output logic [11:0]             speedCmd,      // Speed command r/min
  output logic [8:0]              torqueLimit,   // Torque limit percent
  output logic                    torqueLimitOn, // Limiting in force
  output logic                    torqueAtLimitFlag // Torque at limit
);
  import mrc_pkg::*;

  typedef struct packed {
    mrc_state_e                  state;
    logic                        dirCw;
    mrc_src_e                    src;
    logic [TL_TERMS-1:0]         tlMask;
    logic [11:0]                 sGain;
    logic [11:0]                 sOfs;
    logic [11:0]                 sHi;
    logic [11:0]                 sLo;
    logic [8:0]                  tGain;
    logic [8:0]                  tOfs;
    logic [8:0]                  tMax;
    mrc_entry_s [DATA_SETS-1:0]  tbl;
    logic                        ack;
    logic [31:0]                 rdata;
    logic [11:0]                 speedCmd;
    logic [8:0]                  trqLim;
    logic                        tlOn;
    logic                        torque_at_limit_flag;
    logic                        cw;
    logic                        decelP;
    logic                        instP;
  } mrc_q_s;

  localparam mrc_q_s Q_RST = '{
    state:  ST_IDLE,
    dirCw:  DIR_RST,
    src:    SRC_DIGITAL,
    sGain:  SPD_GAIN_RST,
    sHi:    SPD_HI_RST,
    sLo:    SPD_LO_RST,
    tGain:  TRQ_GAIN_RST,
    tMax:   TRQ_MAX_RST,
    tbl:    '{default: ENTRY_RST},
    default: '0
  };

  mrc_q_s q_r;
  mrc_q_s q_nxt;

  function automatic logic signed [19:0] sx(input logic [11:0] v);
    return {{8{v[11]}}, v};
  endfunction

  function automatic logic signed [19:0] ux(input logic [11:0] v);
    return {8'h00, v};
  endfunction

  // Quotient stays below 2^17 for any 12-bit gain and 14-bit voltage.
  function automatic logic signed [19:0] scale(input logic [11:0] g,
                                               input logic [13:0] mv);
    logic [25:0] p;
    logic [25:0] d;
    p = {14'h0000, g} * {12'h000, mv};
    d = p / MV_PER_V;
    return {3'h0, d[16:0]};
  endfunction

  // The floor is applied last, so a floor above the cap wins.
  function automatic logic [11:0] clampS(input logic signed [19:0] v,
                                         input logic signed [19:0] lo,
                                         input logic signed [19:0] hi);
    logic signed [19:0] r;
    r = v;
    if (r > hi) begin
      r = hi;
    end
    if (r < lo) begin
      r = lo;
    end
    return r[11:0];
  endfunction

  function automatic logic dHit(input logic [7:0] a);
    logic [7:0] o;
    o = a - OFS_DATA;
    return (a >= OFS_DATA) && (a[1:0] == 2'h0) && ({2'h0, o[7:2]} < 8'(DATA_SETS));
  endfunction

  function automatic logic [SEL_W-1:0] dIdx(input logic [7:0] a);
    logic [7:0] o;
    o = a - OFS_DATA;
    return o[2 +: SEL_W];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] rdMux(input mrc_q_s s, input logic [7:0] a);
    logic [31:0] r;
    r = '0;
    case (a)
      OFS_CTRL: begin
        r[CTRL_DIR_BIT] = s.dirCw;
        r[CTRL_SEL_LSB +: 2] = s.src;
        r[CTRL_TLM_LSB +: TL_TERMS] = s.tlMask;
      end
      OFS_SPD_GAIN: r[11:0] = s.sGain;
      OFS_SPD_OFS:  r = 32'(sx(s.sOfs));
      OFS_SPD_HI:   r[11:0] = s.sHi;
      OFS_SPD_LO:   r[11:0] = s.sLo;
      OFS_TRQ_GAIN: r[8:0] = s.tGain;
      OFS_TRQ_OFS:  r = 32'(sx({{3{s.tOfs[8]}}, s.tOfs}));
      OFS_TRQ_MAX:  r[8:0] = s.tMax;
      OFS_STATUS: begin
        r[STS_STATE_LSB +: 4] = s.state;
        r[STS_CW_BIT] = s.cw;
        r[STS_TLON_BIT] = s.tlOn;
        r[STS_TLC_BIT] = s.torque_at_limit_flag;
      end
      OFS_CMD: begin
        r[DATA_SPD_LSB +: 12] = s.speedCmd;
        r[DATA_TRQ_LSB +: 9] = s.trqLim;
      end
      default: begin
        if (dHit(a)) begin
          r[DATA_SPD_LSB +: 12] = s.tbl[dIdx(a)].spd;
          r[DATA_TRQ_LSB +: 9] = s.tbl[dIdx(a)].trq;
        end
      end
    endcase
    return r;
  endfunction

  logic        req;
  logic        fwdOnly;
  logic        bwdOnly;
  logic        tlOn;
  logic        anaSpd;
  logic [11:0] spdAna;
  logic [8:0]  trqAna;
  logic [11:0] spdSel;
  logic [8:0]  trqSel;
  mrc_entry_s  entry;

  assign req     = avReq.read | avReq.write;
  assign fwdOnly = forwardRunInput & ~backwardRunInput;
  assign bwdOnly = backwardRunInput & ~forwardRunInput;

  // A masked-out terminal counts as on; with no terminal assigned the enable is on.
  assign tlOn = &(torqueLimitEnableInput | ~q_r.tlMask); // R16

  // Gain and offset are formed before the limits are applied.
  assign spdAna = clampS(scale(q_r.sGain, analogMv) + sx(q_r.sOfs), // R8 R9 R23
                         ux(q_r.sLo), ux(q_r.sHi)); // R10 R11
  assign trqAna = 9'(clampS(scale({3'h0, q_r.tGain}, analogMv) // R19
                            + sx({{3{q_r.tOfs[8]}}, q_r.tOfs}), // R20
                            B_ZERO, ux({3'h0, q_r.tMax}))); // R21

  assign entry  = q_r.tbl[dataSelect]; // R22
  assign anaSpd = (q_r.src == SRC_ANA_SPD) ||
                  ((q_r.src == SRC_ANA_DATA1) && (dataSelect == SEL_W'(1)));
  assign spdSel = anaSpd ? spdAna : entry.spd; // R12
  assign trqSel = (q_r.src == SRC_ANA_TRQ) ? trqAna : entry.trq; // R12

  always_comb begin
    logic [31:0] wv;
    wv = '0;
    q_nxt = q_r;
    q_nxt.decelP = 1'b0;
    q_nxt.instP = 1'b0;

    // Bus: one wait cycle, read data captured while the request waits.
    q_nxt.ack = req & ~q_r.ack;
    if (req && !q_r.ack) begin
      q_nxt.rdata = avReq.read ? rdMux(q_r, avReq.address) : '0;
    end
    if (avReq.write && q_r.ack) begin
      wv = merge(rdMux(q_r, avReq.address), avReq.writedata, avReq.byteenable);
      case (avReq.address)
        OFS_CTRL: begin
          q_nxt.dirCw = wv[CTRL_DIR_BIT];
          q_nxt.src = mrc_src_e'(wv[CTRL_SEL_LSB +: 2]);
          q_nxt.tlMask = wv[CTRL_TLM_LSB +: TL_TERMS];
        end
        OFS_SPD_GAIN: q_nxt.sGain = clampS(ux(wv[11:0]), B_ZERO, B_SMAX);
        OFS_SPD_OFS:  q_nxt.sOfs = clampS(sx(wv[11:0]), -B_SOFS, B_SOFS);
        OFS_SPD_HI:   q_nxt.sHi = clampS(ux(wv[11:0]), B_SMIN, B_SMAX);
        OFS_SPD_LO:   q_nxt.sLo = clampS(ux(wv[11:0]), B_SMIN, B_SMAX);
        OFS_TRQ_GAIN: q_nxt.tGain = 9'(clampS(ux({3'h0, wv[8:0]}), B_ZERO, B_TMAX));
        OFS_TRQ_OFS:  q_nxt.tOfs = 9'(clampS(sx({{3{wv[8]}}, wv[8:0]}), -B_TOFS, B_TOFS));
        OFS_TRQ_MAX:  q_nxt.tMax = 9'(clampS(ux({3'h0, wv[8:0]}), B_ZERO, B_TMAX));
        default: begin
          if (dHit(avReq.address)) begin
            q_nxt.tbl[dIdx(avReq.address)].spd =
              clampS(ux(wv[DATA_SPD_LSB +: 12]), B_SMIN, B_SMAX);
            q_nxt.tbl[dIdx(avReq.address)].trq =
              9'(clampS(ux({3'h0, wv[DATA_TRQ_LSB +: 9]}), B_ZERO, B_TMAX)); // R13
          end
        end
      endcase
    end

    // Run decoding. After a both-on stop the motor stays stopped until both inputs drop,
    // so releasing one of them cannot restart it unexpectedly.
    case (q_r.state)
      ST_IDLE: begin
        if (fwdOnly) begin
          q_nxt.state = ST_FWD; // R1
        end else if (bwdOnly) begin
          q_nxt.state = ST_REV; // R2
        end
      end
      ST_FWD, ST_REV: begin
        if (forwardRunInput && backwardRunInput) begin
          q_nxt.state = ST_HOLD; // R3
          q_nxt.decelP = 1'b1;
        end else if ((q_r.state == ST_FWD) ? !forwardRunInput : !backwardRunInput) begin
          q_nxt.state = ST_IDLE; // R4
          q_nxt.decelP = !stopModeIn;
          q_nxt.instP = stopModeIn;
        end
      end
      ST_HOLD: begin
        if (!forwardRunInput && !backwardRunInput) begin
          q_nxt.state = ST_IDLE;
        end
      end
      default: q_nxt.state = ST_IDLE;
    endcase

    // The direction shown while stopped is the last one driven.
    if (q_nxt.state == ST_FWD) begin
      q_nxt.cw = q_r.dirCw; // R7
    end else if (q_nxt.state == ST_REV) begin
      q_nxt.cw = !q_r.dirCw; // R7
    end

    q_nxt.speedCmd = spdSel;
    q_nxt.trqLim = trqSel;
    q_nxt.tlOn = tlOn; // R14 R15
    // Below about 20% the comparison may chatter; the flag is passed on unfiltered.
    q_nxt.torque_at_limit_flag = tlOn && (motorTorque >= trqSel); // R17
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q_r <= Q_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign avWaitrequest     = req & ~q_r.ack;
  assign avReaddata        = q_r.rdata;
  assign motorRun          = (q_r.state == ST_FWD) || (q_r.state == ST_REV);
  assign shaftCw           = q_r.cw;
  assign decelStop         = q_r.decelP;
  assign instantStop       = q_r.instP;
  assign speedCmd          = q_r.speedCmd;
  assign torqueLimit       = q_r.trqLim;
  assign torqueLimitOn     = q_r.tlOn;
  assign torqueAtLimitFlag = q_r.torque_at_limit_flag;

  default clocking mrcCb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  AST_FWD_START: assert property ( // R1
    q_r.state == ST_IDLE && fwdOnly |=> motorRun && q_r.state == ST_FWD
  ) else $error("Forward input did not start forward rotation.");

  AST_REV_START: assert property ( // R2
    q_r.state == ST_IDLE && bwdOnly |=> motorRun && q_r.state == ST_REV
  ) else $error("Backward input did not start reverse rotation.");

  AST_BOTH_STOP: assert property ( // R3
    motorRun && forwardRunInput && backwardRunInput
    |=> decelStop && !instantStop && !motorRun ##1 !decelStop
  ) else $error("Both run inputs did not give one decelerating stop.");

  AST_RELEASE_STOP: assert property ( // R4
    motorRun && ((q_r.state == ST_FWD) ? !forwardRunInput : !backwardRunInput)
    |=> !motorRun && instantStop == $past(stopModeIn) && decelStop != $past(stopModeIn)
  ) else $error("Released run input gave the wrong stop.");

  AST_DIR_MAP: assert property ( // R7
    $rose(motorRun) |-> shaftCw == ($past(q_r.dirCw) ^ (q_r.state == ST_REV))
  ) else $error("Shaft direction does not follow the direction setting.");

  AST_SPD_GAIN: assert property ( // R8
    anaSpd && analogMv == 14'h03E8 && q_r.sOfs == 12'h000 &&
    q_r.sGain >= q_r.sLo && q_r.sGain <= q_r.sHi
    |=> speedCmd == $past(q_r.sGain)
  ) else $error("Speed at one volt differs from the gain.");

  AST_SPD_RANGE: assert property ( // R10 R11
    anaSpd && q_r.sLo <= q_r.sHi
    |=> speedCmd >= $past(q_r.sLo) && speedCmd <= $past(q_r.sHi)
  ) else $error("Analog speed command left its limits.");

  AST_TRQ_MAX: assert property ( // R21 R13
    q_r.src == SRC_ANA_TRQ
    |=> torqueLimit <= $past(q_r.tMax) && torqueLimit <= TRQ_MAX_RST
  ) else $error("Analog torque limit exceeds its maximum.");

  AST_TL_DEFAULT: assert property ( // R16
    q_r.tlMask == '0 |=> torqueLimitOn
  ) else $error("Unassigned enable did not read as on.");

  AST_TL_OFF: assert property ( // R15
    !tlOn |=> !torqueLimitOn && !torqueAtLimitFlag
  ) else $error("Limiting stayed active with enable off.");

  AST_TLC_SET: assert property ( // R17 R14
    tlOn && motorTorque >= trqSel |=> torqueAtLimitFlag && torqueLimitOn
  ) else $error("Torque at limit was not flagged.");

  AST_BUS_WAIT: assert property (
    req && avWaitrequest |=> !avWaitrequest ##1 (avWaitrequest == req)
  ) else $error("Bus wait state is not exactly one cycle.");

endmodule // mrc_core
`default_nettype wire

// ===== verilog/mrc_pkg.sv
// Purpose: Shared constants and types of the motor run, speed and torque command block.
// Assumes: Byte addresses on the register bus, one 32-bit word per register.
// Notes:   Bounds are 20-bit signed so that they meet the scaling arithmetic unchanged.
`default_nettype none
package mrc_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_SPD_GAIN = 8'h04;
  localparam logic [7:0] OFS_SPD_OFS  = 8'h08;
  localparam logic [7:0] OFS_SPD_HI   = 8'h0C;
  localparam logic [7:0] OFS_SPD_LO   = 8'h10;
  localparam logic [7:0] OFS_TRQ_GAIN = 8'h14;
  localparam logic [7:0] OFS_TRQ_OFS  = 8'h18;
  localparam logic [7:0] OFS_TRQ_MAX  = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_CMD      = 8'h24;
  localparam logic [7:0] OFS_DATA     = 8'h40;

  // Field positions.
  localparam int unsigned CTRL_DIR_BIT  = 0;
  localparam int unsigned CTRL_SEL_LSB  = 1;
  localparam int unsigned CTRL_TLM_LSB  = 4;
  localparam int unsigned STS_STATE_LSB = 0;
  localparam int unsigned STS_CW_BIT    = 4;
  localparam int unsigned STS_TLON_BIT  = 5;
  localparam int unsigned STS_TLC_BIT   = 6;
  localparam int unsigned DATA_SPD_LSB  = 0;
  localparam int unsigned DATA_TRQ_LSB  = 16;

  // Reset values.
  localparam logic        DIR_RST      = 1'b1;
  localparam logic [11:0] SPD_GAIN_RST = 12'h352;
  localparam logic [11:0] SPD_HI_RST   = 12'hFA0;
  localparam logic [11:0] SPD_LO_RST   = 12'h032;
  localparam logic [8:0]  TRQ_GAIN_RST = 9'h041;
  localparam logic [8:0]  TRQ_MAX_RST  = 9'h12C;

  // Setting bounds.
  localparam logic signed [19:0] B_ZERO = 20'sh00000;
  localparam logic signed [19:0] B_SMIN = 20'sh00032;
  localparam logic signed [19:0] B_SMAX = 20'sh00FA0;
  localparam logic signed [19:0] B_SOFS = 20'sh007D0;
  localparam logic signed [19:0] B_TMAX = 20'sh0012C;
  localparam logic signed [19:0] B_TOFS = 20'sh00096;
  localparam logic [25:0]        MV_PER_V = 26'h00003E8;

  typedef enum logic [1:0] {
    SRC_DIGITAL   = 2'h0,
    SRC_ANA_DATA1 = 2'h1,
    SRC_ANA_SPD   = 2'h2,
    SRC_ANA_TRQ   = 2'h3
  } mrc_src_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_FWD  = 4'h2,
    ST_REV  = 4'h4,
    ST_HOLD = 4'h8
  } mrc_state_e;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } mrc_avreq_s;

  typedef struct packed {
    logic [8:0]  trq;
    logic [11:0] spd;
  } mrc_entry_s;

  localparam mrc_entry_s ENTRY_RST = '{trq: TRQ_MAX_RST, spd: SPD_LO_RST};
endpackage
`default_nettype wire
